// ### external_pin_interrupt_unit.sv
/*
  External pin interrupt unit: two dedicated pins with selectable sense,
  four pin-change groups, and the byte registers that control them.
  Assumes pins and bus requests are synchronous to i_clk, and that the
  core presents the global interrupt enable and a one-cycle acknowledge
  per source when it enters that source's vector.
*/
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Sense field: low, change, fall, rise
// - Pin one sense bits 3:2, zero 1:0
// - Sample pin with clock before detection
// - Pulses over one clock always detected
// - Request needs mask bit and global enable
// - Pin activity counts even as output
// - Each dedicated pin has own vector
// - Edge or change sets pin flag
// - Vector entry clears pin flag
// - Writing one clears flag, zero ignored
// - Flag reads zero in low-level mode
// - Group enables gate four pin groups
// - Per-pin masks select contributing pins
// - Each group has own vector request
// - Low registers answer I/O address minus 0x20
// - Extended registers reachable by data space only
// - Group change sets flag, W1C or ack
// - Change and level detection need no edges; here both work on clock-sampled pins
// - Level request held while pin low
module external_pin_interrupt_unit
  import pin_irq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire bus_req_t i_bus,
  input wire logic [1:0] i_ext_irq_pin,
  input wire logic [NUM_PC_PINS-1:0] i_pin_change_input,
  input wire logic i_global_ie,
  input wire logic [1:0] i_ext_ack,
  input wire logic [NUM_GROUPS-1:0] i_grp_ack,
  output logic [7:0] o_rdata,
  output logic [1:0] o_ext_req,
  output logic [NUM_GROUPS-1:0] o_grp_req
);

  // Sampled pins and their previous samples.
  logic [1:0] ext_pin_reg, ext_pin_next;
  logic [1:0] ext_prev_reg, ext_prev_next;
  logic [NUM_PC_PINS-1:0] pc_pin_reg, pc_pin_next;
  logic [NUM_PC_PINS-1:0] pc_prev_reg, pc_prev_next;

  // Software-visible registers.
  logic [7:0] sense_ctrl_reg, sense_ctrl_next;
  logic [1:0] ext_mask_reg, ext_mask_next;
  logic [1:0] ext_flags_reg, ext_flags_next;
  logic [3:0] grp_enable_reg, grp_enable_next;
  logic [3:0] pc_flags_reg, pc_flags_next;
  logic [7:0] pc_mask0_reg, pc_mask0_next;
  logic [6:0] pc_mask1_reg, pc_mask1_next;
  logic [7:0] pc_mask2_reg, pc_mask2_next;
  logic [3:0] pc_mask3_reg, pc_mask3_next;

  // Output registers.
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] ext_req_reg, ext_req_next;
  logic [3:0] grp_req_reg, grp_req_next;

  // Decoded data-space address and detection terms.
  logic [7:0] eff_addr;
  logic addr_ok;
  logic [1:0] sense_mode [2];
  logic [1:0] ext_event;
  logic [1:0] ext_level;
  logic [NUM_PC_PINS-1:0] pc_change;
  logic [NUM_PC_PINS-1:0] pc_pin_mask;
  logic [3:0] grp_event;
  logic wr_ext_flags, wr_pc_flags;

  // Input sampling: pins pass one register before any detection.
  // The previous sample resets low, so a pin that idles high shows one
  // false rising edge after reset; the sense fields reset to low level,
  // which holds the flags clear, so that edge latches only if a sense field is written at the first clock edge after reset.
  always_comb begin
    ext_pin_next = i_ext_irq_pin;
    ext_prev_next = ext_pin_reg;
    pc_pin_next = i_pin_change_input;
    pc_prev_next = pc_pin_reg;
  end

  // Address translation: I/O instructions reach only the low range.
  // An I/O address at or above the window is refused: writes are dropped
  // and reads return zero, which keeps the extended registers data-space only.
  always_comb begin
    if (i_bus.io_space) begin
      eff_addr = i_bus.addr + IO_SPACE_SHIFT;
      addr_ok = (i_bus.addr < IO_SPACE_LIMIT);
    end else begin
      eff_addr = i_bus.addr;
      addr_ok = 1'b1;
    end
  end

  // Event detection on the sampled pins.
  // Edge and change terms compare two consecutive samples, so a pulse must
  // be held across at least one rising clock edge to be seen.
  always_comb begin
    sense_mode[0] = sense_ctrl_reg[SENSE_ZERO_LSB +: 2];
    sense_mode[1] = sense_ctrl_reg[SENSE_ONE_LSB +: 2];
    for (int i = 0; i < 2; i++) begin
      // Low level is seen directly from the sampled pin.
      ext_level[i] = ~ext_pin_reg[i];
      unique case (sense_mode_t'(sense_mode[i]))
        SENSE_LOW_LEVEL: begin
          ext_event[i] = 1'b0;
        end
        SENSE_ANY_CHANGE: begin
          ext_event[i] = ext_pin_reg[i] ^ ext_prev_reg[i];
        end
        SENSE_FALLING: begin
          ext_event[i] = ext_prev_reg[i] & ~ext_pin_reg[i];
        end
        SENSE_RISING: begin
          ext_event[i] = ~ext_prev_reg[i] & ext_pin_reg[i];
        end
      endcase
    end
    pc_pin_mask = '0;
    pc_pin_mask[GRP0_LSB +: 8] = pc_mask0_reg;
    pc_pin_mask[GRP1_LSB +: 7] = pc_mask1_reg;
    pc_pin_mask[GRP2_LSB +: 8] = pc_mask2_reg;
    pc_pin_mask[GRP3_LSB +: 4] = pc_mask3_reg;
    pc_change = (pc_pin_reg ^ pc_prev_reg) & pc_pin_mask;
    grp_event[0] = |pc_change[GRP0_LSB +: 8];
    grp_event[1] = |pc_change[GRP1_LSB +: 7];
    grp_event[2] = |pc_change[GRP2_LSB +: 8];
    grp_event[3] = |pc_change[GRP3_LSB +: 4];
  end

  // Register writes, flag updates and read data.
  // Unused register bits are dropped on write and read back as zero.
  always_comb begin
    sense_ctrl_next = sense_ctrl_reg;
    ext_mask_next = ext_mask_reg;
    grp_enable_next = grp_enable_reg;
    pc_mask0_next = pc_mask0_reg;
    pc_mask1_next = pc_mask1_reg;
    pc_mask2_next = pc_mask2_reg;
    pc_mask3_next = pc_mask3_reg;
    wr_ext_flags = 1'b0;
    wr_pc_flags = 1'b0;
    rdata_next = rdata_reg;
    // Plain read/write registers.
    if (i_bus.wr && addr_ok) begin
      unique case (eff_addr)
        OFS_SENSE_CTRL: sense_ctrl_next = {4'h0, i_bus.wdata[3:0]};
        OFS_EXT_MASK: ext_mask_next = i_bus.wdata[1:0];
        OFS_GRP_ENABLE: grp_enable_next = i_bus.wdata[3:0];
        OFS_PC_MASK0: pc_mask0_next = i_bus.wdata;
        OFS_PC_MASK1: pc_mask1_next = i_bus.wdata[6:0];
        OFS_PC_MASK2: pc_mask2_next = i_bus.wdata;
        OFS_PC_MASK3: pc_mask3_next = i_bus.wdata[3:0];
        OFS_EXT_FLAGS: wr_ext_flags = 1'b1;
        OFS_PC_FLAGS: wr_pc_flags = 1'b1;
        default: begin
          // Unmapped writes are ignored.
        end
      endcase
    end
    // Dedicated pin flags: set beats every clear in the same cycle.
    for (int i = 0; i < 2; i++) begin
      ext_flags_next[i] = ext_flags_reg[i];
      if (wr_ext_flags && i_bus.wdata[i]) begin
        ext_flags_next[i] = 1'b0;
      end
      if (i_ext_ack[i]) begin
        ext_flags_next[i] = 1'b0;
      end
      if (ext_event[i]) begin
        ext_flags_next[i] = 1'b1;
      end
      if (sense_mode[i] == SENSE_LOW_LEVEL) begin
        ext_flags_next[i] = 1'b0;
      end
    end
    // Group flags follow the same priority.
    for (int g = 0; g < NUM_GROUPS; g++) begin
      pc_flags_next[g] = pc_flags_reg[g];
      if ((wr_pc_flags && i_bus.wdata[g]) || i_grp_ack[g]) begin
        pc_flags_next[g] = 1'b0;
      end
      if (grp_event[g]) begin
        pc_flags_next[g] = 1'b1;
      end
    end
    // Reads return the register one cycle later; unmapped reads zero.
    if (i_bus.rd) begin
      rdata_next = REG_RESET;
      if (addr_ok) begin
        unique case (eff_addr)
          OFS_SENSE_CTRL: rdata_next = sense_ctrl_reg;
          OFS_EXT_MASK: rdata_next = {6'h00, ext_mask_reg};
          OFS_EXT_FLAGS: rdata_next = {6'h00, ext_flags_reg};
          OFS_GRP_ENABLE: rdata_next = {4'h0, grp_enable_reg};
          OFS_PC_FLAGS: rdata_next = {4'h0, pc_flags_reg};
          OFS_PC_MASK0: rdata_next = pc_mask0_reg;
          OFS_PC_MASK1: rdata_next = {1'b0, pc_mask1_reg};
          OFS_PC_MASK2: rdata_next = pc_mask2_reg;
          OFS_PC_MASK3: rdata_next = {4'h0, pc_mask3_reg};
          default: rdata_next = REG_RESET;
        endcase
      end
    end
  end

  // Requests toward the core, one line per vector.
  // Level mode bypasses the flag: the request follows the sampled pin, so it
  // falls two cycles after the pin is released, with no latch left to clear.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (sense_mode[i] == SENSE_LOW_LEVEL) begin
        ext_req_next[i] = ext_mask_reg[i] & i_global_ie & ext_level[i];
      end else begin
        ext_req_next[i] = ext_mask_reg[i] & i_global_ie & ext_flags_reg[i];
      end
    end
    grp_req_next = grp_enable_reg & pc_flags_reg & {NUM_GROUPS{i_global_ie}};
  end

  // State registers; every one resets to zero.
  // Flags and requests clear at once on reset, so no stale request survives it.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_pin_reg <= 2'h0;
      ext_prev_reg <= 2'h0;
      pc_pin_reg <= '0;
      pc_prev_reg <= '0;
      sense_ctrl_reg <= REG_RESET;
      ext_mask_reg <= 2'h0;
      ext_flags_reg <= 2'h0;
      grp_enable_reg <= 4'h0;
      pc_flags_reg <= 4'h0;
      pc_mask0_reg <= 8'h00;
      pc_mask1_reg <= 7'h00;
      pc_mask2_reg <= 8'h00;
      pc_mask3_reg <= 4'h0;
      rdata_reg <= REG_RESET;
      ext_req_reg <= 2'h0;
      grp_req_reg <= 4'h0;
    end else begin
      ext_pin_reg <= ext_pin_next;
      ext_prev_reg <= ext_prev_next;
      pc_pin_reg <= pc_pin_next;
      pc_prev_reg <= pc_prev_next;
      sense_ctrl_reg <= sense_ctrl_next;
      ext_mask_reg <= ext_mask_next;
      ext_flags_reg <= ext_flags_next;
      grp_enable_reg <= grp_enable_next;
      pc_flags_reg <= pc_flags_next;
      pc_mask0_reg <= pc_mask0_next;
      pc_mask1_reg <= pc_mask1_next;
      pc_mask2_reg <= pc_mask2_next;
      pc_mask3_reg <= pc_mask3_next;
      rdata_reg <= rdata_next;
      ext_req_reg <= ext_req_next;
      grp_req_reg <= grp_req_next;
    end
  end

  // Outputs come straight from registers.
  // The core therefore sees clean levels that never glitch between edges.
  assign o_rdata = rdata_reg;
  assign o_ext_req = ext_req_reg;
  assign o_grp_req = grp_req_reg;

endmodule : external_pin_interrupt_unit

`default_nettype wire

// ### pin_irq_pkg.sv
/*
  Shared constants and types for the external pin interrupt unit.
  Assumes a core that reaches registers by byte address in its data space.
*/
package pin_irq_pkg;

  // Data-space offsets of the registers, as byte addresses.
  localparam logic [7:0] OFS_PC_FLAGS = 8'h3b;
  localparam logic [7:0] OFS_EXT_FLAGS = 8'h3c;
  localparam logic [7:0] OFS_EXT_MASK = 8'h3d;
  localparam logic [7:0] OFS_GRP_ENABLE = 8'h68;
  localparam logic [7:0] OFS_SENSE_CTRL = 8'h69;
  localparam logic [7:0] OFS_PC_MASK0 = 8'h6b;
  localparam logic [7:0] OFS_PC_MASK1 = 8'h6c;
  localparam logic [7:0] OFS_PC_MASK2 = 8'h6d;
  localparam logic [7:0] OFS_PC_MASK3 = 8'h73;

  // I/O instructions see the low range shifted down by this amount.
  localparam logic [7:0] IO_SPACE_SHIFT = 8'h20;
  // First address above the I/O instruction range.
  localparam logic [7:0] IO_SPACE_LIMIT = 8'h40;

  // Sense field positions inside the sense control register.
  localparam int SENSE_ONE_LSB = 2;
  localparam int SENSE_ZERO_LSB = 0;

  // Pin group boundaries on the pin-change input vector.
  localparam int GRP0_LSB = 0;
  localparam int GRP1_LSB = 8;
  localparam int GRP2_LSB = 16;
  localparam int GRP3_LSB = 24;
  localparam int NUM_PC_PINS = 28;
  localparam int NUM_GROUPS = 4;

  // Reset value common to every register.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Trigger selections of one sense field.
  typedef enum logic [1:0] {
    SENSE_LOW_LEVEL = 2'h0,
    SENSE_ANY_CHANGE = 2'h1,
    SENSE_FALLING = 2'h2,
    SENSE_RISING = 2'h3
  } sense_mode_t;

  // One register access from the core.
  typedef struct packed {
    logic [7:0] addr;
    logic io_space;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } bus_req_t;

endpackage : pin_irq_pkg

// ### pin_irq_asserts.sv
/*
  Checker for the external pin interrupt unit.
  Sees only the unit's ports and is bound to it below.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_irq_asserts
  import pin_irq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire bus_req_t i_bus,
  input wire logic [1:0] i_ext_irq_pin,
  input wire logic [NUM_PC_PINS-1:0] i_pin_change_input,
  input wire logic i_global_ie,
  input wire logic [1:0] i_ext_ack,
  input wire logic [NUM_GROUPS-1:0] i_grp_ack,
  input wire logic [7:0] o_rdata,
  input wire logic [1:0] o_ext_req,
  input wire logic [NUM_GROUPS-1:0] o_grp_req
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // A data-space read in this cycle.
  wire logic data_rd = i_bus.rd && !i_bus.io_space;
  req_needs_ie_a: assert property (o_ext_req != 2'h0 |-> $past(i_global_ie))
    else $error("pin request without global enable");
  grp_needs_ie_a: assert property (o_grp_req != 4'h0 |-> $past(i_global_ie))
    else $error("group request without global enable");
  // acknowledge clears flag; the pin is high for three samples so no event lands.
  ack_clears_a: assert property (i_ext_ack[0] && i_ext_irq_pin[0] && $past(i_ext_irq_pin[0])
    && $past(i_ext_irq_pin[0], 2) && !$past(i_rst) && !$past(i_rst, 2) |-> ##2 !o_ext_req[0])
    else $error("pin zero request survived its acknowledge");
  mask_gates_a: assert property (i_bus.wr && !i_bus.io_space && i_bus.addr == OFS_EXT_MASK
    && i_bus.wdata[1:0] == 2'h0 |-> ##2 o_ext_req == 2'h0)
    else $error("pin request after mask cleared");
  grp_gates_a: assert property (i_bus.wr && !i_bus.io_space && i_bus.addr == OFS_GRP_ENABLE
    && i_bus.wdata[3:0] == 4'h0 |-> ##2 o_grp_req == 4'h0)
    else $error("group request after enables cleared");
  // Read data only moves after a read.
  rdata_holds_a: assert property (!$past(i_bus.rd) |-> $stable(o_rdata))
    else $error("read data changed without a read");
  io_range_a: assert property (i_bus.rd && i_bus.io_space && i_bus.addr >= IO_SPACE_LIMIT
    |=> o_rdata == 8'h00)
    else $error("read above the I/O window returned data");
  sense_width_a: assert property (data_rd && i_bus.addr == OFS_SENSE_CTRL
    |=> o_rdata[7:4] == 4'h0)
    else $error("sense register upper bits not zero");
  // Unmapped data address reads zero.
  unmapped_zero_a: assert property (data_rd && i_bus.addr == 8'h00 |=> o_rdata == 8'h00)
    else $error("unmapped address returned data");
  cover property (o_ext_req[0] ##1 i_ext_ack[0]);
  cover property ($rose(o_grp_req[2]));
  cover property (i_bus.rd && i_bus.io_space);
endmodule : pin_irq_asserts
bind external_pin_interrupt_unit pin_irq_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_bus(i_bus), .i_ext_irq_pin(i_ext_irq_pin), .i_pin_change_input(i_pin_change_input),
  .i_global_ie(i_global_ie), .i_ext_ack(i_ext_ack), .i_grp_ack(i_grp_ack),
  .o_rdata(o_rdata), .o_ext_req(o_ext_req), .o_grp_req(o_grp_req));
`default_nettype wire

// ### core_ack_model.sv
/*
  Core-side model: acknowledges each pending vector with a one-cycle pulse.
  Assumes registered request levels on the rising edge of i_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module core_ack_model (
  input wire logic i_clk,
  input wire logic [1:0] i_ext_req,
  input wire logic [3:0] i_grp_req,
  output logic [1:0] o_ext_ack,
  output logic [3:0] o_grp_ack
);
  logic [5:0] ack_last; // Pulse of the cycle before, blocks a repeat.
  initial begin
    o_ext_ack = 2'h0;
    o_grp_ack = 4'h0;
    ack_last = 6'h00;
  end
  // one-cycle acknowledge; no second pulse while the clear lands.
  always @(negedge i_clk) begin
    {o_grp_ack, o_ext_ack} <= {i_grp_req, i_ext_req} & ~{o_grp_ack, o_ext_ack} & ~ack_last;
    ack_last <= {o_grp_ack, o_ext_ack};
  end
endmodule : core_ack_model
`default_nettype wire

// ### external_pin_interrupt_unit_test.sv
/*
  Self-checking bench for the external pin interrupt unit.
  Drives pins and bus on the falling edge; the core model acknowledges.
*/
`timescale 1ns/100ps
`default_nettype none
module external_pin_interrupt_unit_test;
  import pin_irq_pkg::*;
  logic clk, rst, ie;
  bus_req_t bus;
  logic [1:0] ext_pin, ext_ack, ext_req;
  logic [NUM_PC_PINS-1:0] pc_pin;
  logic [3:0] grp_ack, grp_req;
  logic [7:0] rdata;
  int errors, checks_done;
  external_pin_interrupt_unit u_dut (.i_clk(clk), .i_rst(rst), .i_bus(bus),
    .i_ext_irq_pin(ext_pin), .i_pin_change_input(pc_pin), .i_global_ie(ie),
    .i_ext_ack(ext_ack), .i_grp_ack(grp_ack), .o_rdata(rdata), .o_ext_req(ext_req),
    .o_grp_req(grp_req));
  core_ack_model u_core (.i_clk(clk), .i_ext_req(ext_req), .i_grp_req(grp_req),
    .o_ext_ack(ext_ack), .o_grp_ack(grp_ack));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compares and counts one value.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One bus cycle, released a full cycle later.
  task automatic access(input logic [7:0] a, input logic io, input logic w, input logic [7:0] d);
    @(negedge clk);
    bus = '{addr: a, io_space: io, wr: w, rd: !w, wdata: d};
    @(negedge clk);
    bus = '0;
  endtask : access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(a, 1'b0, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic io, input logic [7:0] exp);
    access(a, io, 1'b0, 8'h00);
    check(rdata, exp);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  // True when mode md fires on a fall (r=0) or a rise (r=1).
  function automatic logic hit(input int md, input int r);
    return (md == 1) || (md == 2 + r);
  endfunction : hit
  task automatic t_reset;
    logic [7:0] ofs [9] = '{OFS_PC_FLAGS, OFS_EXT_FLAGS, OFS_EXT_MASK, OFS_GRP_ENABLE,
      OFS_SENSE_CTRL, OFS_PC_MASK0, OFS_PC_MASK1, OFS_PC_MASK2, OFS_PC_MASK3};
    foreach (ofs[i]) rd(ofs[i], 1'b0, REG_RESET);
  endtask : t_reset
  task automatic t_regs;
    access(OFS_EXT_MASK - IO_SPACE_SHIFT, 1'b1, 1'b1, 8'hff);
    rd(OFS_EXT_MASK, 1'b0, 8'h03);
    rd(OFS_EXT_MASK - IO_SPACE_SHIFT, 1'b1, 8'h03);
    wr(OFS_SENSE_CTRL, 8'hff);
    access(OFS_SENSE_CTRL - IO_SPACE_SHIFT, 1'b1, 1'b1, 8'h00);
    rd(OFS_SENSE_CTRL, 1'b0, 8'h0f);
    rd(OFS_SENSE_CTRL - IO_SPACE_SHIFT, 1'b1, 8'h00);
    wr(OFS_GRP_ENABLE, 8'hff);
    rd(OFS_GRP_ENABLE, 1'b0, 8'h0f);
    rd(8'h00, 1'b0, 8'h00);
  endtask : t_regs
  // Every sense mode; pin one runs the mirror mode of pin zero.
  task automatic t_modes;
    logic [7:0] e;
    for (int m = 0; m < 4; m++) begin
      wr(OFS_SENSE_CTRL, {4'h0, 2'(3 - m), 2'(m)});
      wr(OFS_EXT_FLAGS, 8'h03);
      ext_pin = 2'b00;
      idle(4);
      rd(OFS_EXT_FLAGS, 1'b0, {6'h00, hit(3 - m, 0), hit(m, 0)});
      wr(OFS_EXT_FLAGS, 8'h03);
      ext_pin = 2'b11;
      idle(4);
      e = {6'h00, hit(3 - m, 1), hit(m, 1)};
      rd(OFS_EXT_FLAGS, 1'b0, e);
      wr(OFS_EXT_FLAGS, 8'h00);
      rd(OFS_EXT_FLAGS, 1'b0, e);
    end
  endtask : t_modes
  task automatic t_req;
    wr(OFS_SENSE_CTRL, 8'h0f);
    ext_pin = 2'b00;
    idle(3);
    wr(OFS_EXT_FLAGS, 8'h03);
    wr(OFS_EXT_MASK, 8'h01);
    ie = 1'b1;
    ext_pin = 2'b11;
    for (int i = 0; i < 8 && ext_req[0] !== 1'b1; i++) @(negedge clk);
    check({6'h00, ext_req}, 8'h01);
    idle(5);
    check({6'h00, ext_req}, 8'h00);
    rd(OFS_EXT_FLAGS, 1'b0, 8'h02);
    wr(OFS_SENSE_CTRL, 8'h0c);
    ext_pin[0] = 1'b0;
    idle(3);
    check({6'h00, ext_req}, 8'h01);
    idle(6);
    check({6'h00, ext_req}, 8'h01);
    rd(OFS_EXT_FLAGS, 1'b0, 8'h02);
    ie = 1'b0;
    idle(3);
    check({6'h00, ext_req}, 8'h00);
    wr(OFS_EXT_MASK, 8'h00);
    ext_pin = 2'b11;
    // Pin one in change mode raises only its own request line.
    wr(OFS_SENSE_CTRL, 8'h07);
    wr(OFS_EXT_FLAGS, 8'h03);
    wr(OFS_EXT_MASK, 8'h02);
    ie = 1'b1;
    ext_pin[1] = 1'b0;
    @(negedge clk);
    ext_pin[1] = 1'b1;
    for (int i = 0; i < 8 && ext_req[1] !== 1'b1; i++) @(negedge clk);
    check({6'h00, ext_req}, 8'h02);
    idle(5);
    check({6'h00, ext_req}, 8'h00);
    rd(OFS_EXT_FLAGS, 1'b0, 8'h00);
    ie = 1'b0;
    wr(OFS_EXT_MASK, 8'h00);
  endtask : t_req
  task automatic t_groups;
    wr(OFS_PC_MASK0, 8'hfe);
    wr(OFS_PC_MASK1, 8'hff);
    wr(OFS_PC_MASK2, 8'hff);
    wr(OFS_PC_MASK3, 8'hff);
    pc_pin[0] = 1'b1;
    idle(4);
    rd(OFS_PC_FLAGS, 1'b0, 8'h00);
    for (int g = 0; g < 4; g++) begin
      pc_pin[8 * g + 1] = ~pc_pin[8 * g + 1];
      idle(4);
      rd(OFS_PC_FLAGS, 1'b0, 8'h01 << g);
      wr(OFS_PC_FLAGS, 8'h0f);
    end
    wr(OFS_GRP_ENABLE, 8'h04);
    ie = 1'b1;
    pc_pin = pc_pin ^ 28'h2020202;
    for (int i = 0; i < 8 && grp_req === 4'h0; i++) @(negedge clk);
    check({4'h0, grp_req}, 8'h04);
    idle(5);
    rd(OFS_PC_FLAGS, 1'b0, 8'h0b);
    wr(OFS_GRP_ENABLE, 8'h00);
  endtask : t_groups
  task automatic report_and_stop;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    rst = 1'b1;
    ie = 1'b0;
    bus = '0;
    ext_pin = 2'b11;
    pc_pin = '0;
    errors = 0;
    checks_done = 0;
    idle(5);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_modes();
    t_req();
    t_groups();
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    rd(OFS_SENSE_CTRL, 1'b0, REG_RESET);
    report_and_stop();
  end
  // Cuts a hang short well after the expected run length.
  initial begin
    #(25 * 4000);
    errors++;
    report_and_stop();
  end
endmodule : external_pin_interrupt_unit_test
`default_nettype wire
